/* hw/dsc_pkg.sv */
// display sequencer control: shared constants and carrier types
// assumes a single 40 MHz reference clock domain
package dsc_pkg;
  localparam int CTRL_BITS = 55;
  localparam int STAT_BITS = 4;
  // control string layout, bit 0 is the last bit shifted in
  localparam int F_VSEL = 0;   // 4 bits, active-low vertical selects
  localparam int F_HSEL = 4;   // 2 bits, active-low horizontal selects
  localparam int F_TRGA = 6;   // 3 bits
  localparam int F_TRGB = 9;   // 3 bits
  localparam int F_DSEL = 12;  // delay reference select
  localparam int F_VTRG = 13;  // vertical trigger mode
  localparam int F_ALVL = 14;  // auto level mode
  localparam int F_CHOP = 15;  // chopped vertical mode
  localparam int F_GA3 = 16;
  localparam int F_GA4 = 17;
  localparam int F_INV2 = 18;
  localparam int F_LAMP = 19;  // lamp suppress
  localparam int F_SGL = 20;   // single sequence mode
  localparam int F_HOLD = 21;  // 8 bits holdoff length in units of HOLD_SCALE reference cycles
  localparam int F_INTN = 29;  // 8 bits display intensity
  localparam int F_ROIN = 37;  // 8 bits readout intensity
  // readout permit returns high this many cycles before holdoff ends
  localparam int RO_GUARD = 8;
  // blanking stretch after control change
  localparam int CHG_BLANK = 16;
  localparam int HOLD_SCALE = 4;
  localparam logic [3:0] VSEL_READOUT = 4'hF;
  localparam logic [1:0] HSEL_READOUT = 2'h3;

  typedef struct packed {
    logic [3:0] vsel_n;
    logic [1:0] hsel_n;
    logic [2:0] trg_a;
    logic [2:0] trg_b;
    logic dsel_n;
  } dsc_sel_t;
endpackage : dsc_pkg

/* hw/dsc_top.sv */
// display sequencer control: serial control load, status readback, display
// select outputs. assumes link clock/data/strobe are asynchronous pins and
// analog sweep/trigger status lines arrive asynchronously too.
`timescale 1ns/100ps
// What this block does
// - fifty-five bits shift in, one per rising control clock edge.
// - loaded fields drive the matching control lines.
// - trigger source outputs change only during holdoff.
// - vertical trigger mode tracks vertical channel unless auto-level or chop.
// - four active-low vertical selects pick channel, sum or readout.
// - two horizontal selects pick A, B, X-Y or readout.
// - six lines select trigger A and B sources.
// - holdoff gives sweep recovery and settling after control change.
// - active-low delay select picks delay reference zero or one.
// - four status bits shift out, one per host strobe.
// - beam off during chop switching, readout and control changes.
// - readout mode on sweep gate A end or readout request.
// - gain bits set channel 3 and 4 to 0.1 or 0.5 V/div.
// - channel 2 polarity follows loaded control bit.
// - readout permit low from holdoff start until shortly before end.
module dsc_top (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ctrl_clk,
  input wire logic ctrl_data,
  input wire logic status_shift_strobe,
  input wire logic sweep_gate_a_n,
  input wire logic sweep_gate_b_n,
  input wire logic trig_state_a,
  input wire logic trig_state_b,
  input wire logic readout_request_n,
  input wire logic chop_phase,
  output logic status_serial_out,
  output logic vert_select_1_n,
  output logic vert_select_2_n,
  output logic vert_select_3_n,
  output logic vert_select_4_n,
  output logic horiz_select_a_n,
  output logic horiz_select_b_n,
  output logic trig_a_src_bit0,
  output logic trig_a_src_bit1,
  output logic trig_a_src_bit2,
  output logic trig_b_src_bit0,
  output logic trig_b_src_bit1,
  output logic trig_b_src_bit2,
  output logic trig_holdoff,
  output logic delay_ref_select_n,
  output logic beam_off,
  output logic readout_permit_n,
  output logic [7:0] intensity_drive,
  output logic ch3_gain_sel,
  output logic ch4_gain_sel,
  output logic ch2_polarity_flip,
  output logic lamp_suppress,
  output logic single_sequence_mode
);
  // two-stage synchronisers for every asynchronous pin
  localparam int NS = 9;
  // idle pin levels (gates and request high) so release gives no false edge
  localparam logic [NS-1:0] SYNC_IDLE = 9'h032;
  logic [NS-1:0] s1_q, s2_q;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s1_q <= SYNC_IDLE;
      s2_q <= SYNC_IDLE;
    end else begin
      s1_q <= {ctrl_clk, ctrl_data, status_shift_strobe, sweep_gate_a_n,
               sweep_gate_b_n, trig_state_a, trig_state_b,
               readout_request_n, chop_phase};
      s2_q <= s1_q;
    end
  end
  logic cclk_s, cdat_s, sstb_s, sga_s, sgb_s, tsa_s, tsb_s, ror_s, chop_s;
  assign {cclk_s, cdat_s, sstb_s, sga_s, sgb_s, tsa_s, tsb_s, ror_s,
          chop_s} = s2_q;

  logic cclk_prev_q, sstb_prev_q, sga_prev_q, chop_prev_q;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cclk_prev_q <= 1'b0;
      sstb_prev_q <= 1'b0;
      sga_prev_q <= 1'b1;
      chop_prev_q <= 1'b0;
    end else begin
      cclk_prev_q <= cclk_s;
      sstb_prev_q <= sstb_s;
      sga_prev_q <= sga_s;
      chop_prev_q <= chop_s;
    end
  end
  logic cclk_rise, sstb_rise, sweep_end, chop_edge;
  assign cclk_rise = cclk_s & ~cclk_prev_q;
  assign sstb_rise = sstb_s & ~sstb_prev_q;
  assign sweep_end = sga_s & ~sga_prev_q;
  assign chop_edge = chop_s ^ chop_prev_q;

  // serial control load; shadow copied only on the 55th bit
  logic [dsc_pkg::CTRL_BITS-1:0] shift_q, ctrl_q;
  logic [5:0] cnt_q;
  logic load_q;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      shift_q <= '0;
      ctrl_q <= '0;
      cnt_q <= '0;
      load_q <= 1'b0;
    end else begin
      load_q <= 1'b0;
      if (cclk_rise) begin
        shift_q <= {shift_q[dsc_pkg::CTRL_BITS-2:0], cdat_s};
        if (cnt_q == 6'(dsc_pkg::CTRL_BITS - 1)) begin
          cnt_q <= '0;
          ctrl_q <= {shift_q[dsc_pkg::CTRL_BITS-2:0], cdat_s};
          load_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 6'h01;
        end
      end
    end
  end

  a_load_whole: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    !load_q |-> $stable(ctrl_q))
    else $error("control register changed without full load");

  // holdoff: starts at sweep end or after a new control string
  logic [11:0] hold_cnt_q;
  logic hold_q;
  logic [11:0] hold_len;
  assign hold_len = 12'(ctrl_q[dsc_pkg::F_HOLD +: 8]) *
                    12'(dsc_pkg::HOLD_SCALE) + 12'(dsc_pkg::RO_GUARD) + 12'h1;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      hold_cnt_q <= '0;
      hold_q <= 1'b1;
    end else if (sweep_end || load_q) begin
      hold_cnt_q <= hold_len;
      hold_q <= 1'b1;
    end else if (hold_cnt_q != 12'h0) begin
      hold_cnt_q <= hold_cnt_q - 12'h1;
    end else begin
      hold_q <= 1'b0;
    end
  end

  a_holdoff_start: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    sweep_end |=> ##1 trig_holdoff)
    else $error("holdoff missing after sweep end");

  // readout permit: low during holdoff except final guard window
  always_ff @(posedge ref_clk) begin
    if (!rstn) readout_permit_n <= 1'b1;
    else readout_permit_n <= !(hold_q &&
      hold_cnt_q > 12'(dsc_pkg::RO_GUARD));
  end

  a_permit_guard: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (hold_q && hold_cnt_q <= 12'(dsc_pkg::RO_GUARD)) |=> readout_permit_n)
    else $error("readout permit low in holdoff guard");

  // readout mode after A sweep ends while permitted, or on request at any time
  logic ro_mode;
  assign ro_mode = (!readout_permit_n && sga_s) || !ror_s;

  // vertical channel tracking for trigger follow mode
  logic [1:0] vchan_q;
  always_ff @(posedge ref_clk) begin
    if (!rstn) vchan_q <= '0;
    else if (sweep_end) vchan_q <= vchan_q + 2'h1;
  end
  logic track;
  assign track = ctrl_q[dsc_pkg::F_VTRG] && !ctrl_q[dsc_pkg::F_ALVL]
                 && !ctrl_q[dsc_pkg::F_CHOP];

  dsc_pkg::dsc_sel_t sel_q;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sel_q <= '{vsel_n: dsc_pkg::VSEL_READOUT, hsel_n: dsc_pkg::HSEL_READOUT,
                 trg_a: 3'h0, trg_b: 3'h0, dsel_n: 1'b1};
    end else begin
      if (ro_mode) begin
        sel_q.vsel_n <= dsc_pkg::VSEL_READOUT;
        sel_q.hsel_n <= dsc_pkg::HSEL_READOUT;
      end else begin
        sel_q.vsel_n <= ctrl_q[dsc_pkg::F_VSEL +: 4];
        sel_q.hsel_n <= ctrl_q[dsc_pkg::F_HSEL +: 2];
      end
      if (hold_q) begin
        sel_q.trg_a <= track ? {1'b0, vchan_q}
                             : ctrl_q[dsc_pkg::F_TRGA +: 3];
        sel_q.trg_b <= ctrl_q[dsc_pkg::F_TRGB +: 3];
      end
      sel_q.dsel_n <= ctrl_q[dsc_pkg::F_DSEL];
    end
  end
  a_trig_hold_only: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    !$past(hold_q) |-> $stable(sel_q.trg_a))
    else $error("trigger source changed outside holdoff");
  a_ro_select: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    ro_mode |=> sel_q.vsel_n == dsc_pkg::VSEL_READOUT &&
    sel_q.hsel_n == dsc_pkg::HSEL_READOUT)
    else $error("readout mode did not force selects high");

  assign {vert_select_4_n, vert_select_3_n, vert_select_2_n,
          vert_select_1_n} = sel_q.vsel_n;
  assign {horiz_select_b_n, horiz_select_a_n} = sel_q.hsel_n;
  assign {trig_a_src_bit2, trig_a_src_bit1, trig_a_src_bit0} = sel_q.trg_a;
  assign {trig_b_src_bit2, trig_b_src_bit1, trig_b_src_bit0} = sel_q.trg_b;
  assign delay_ref_select_n = sel_q.dsel_n;

  // blanking; control change stretch keeps beam dark while circuits settle
  logic [4:0] blk_cnt_q;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      blk_cnt_q <= '0;
      beam_off <= 1'b1;
      trig_holdoff <= 1'b1;
    end else begin
      if (load_q) blk_cnt_q <= 5'(dsc_pkg::CHG_BLANK);
      else if (blk_cnt_q != 5'h0) blk_cnt_q <= blk_cnt_q - 5'h1;
      beam_off <= (blk_cnt_q != 5'h0) || load_q || ro_mode ||
                  (ctrl_q[dsc_pkg::F_CHOP] && chop_edge);
      trig_holdoff <= hold_q;
    end
  end

  a_load_blank: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    load_q |=> beam_off [*8])
    else $error("beam not off after control change");

  // auxiliary bits and intensity
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ch3_gain_sel <= 1'b0;
      ch4_gain_sel <= 1'b0;
      ch2_polarity_flip <= 1'b0;
      lamp_suppress <= 1'b0;
      single_sequence_mode <= 1'b0;
      intensity_drive <= '0;
    end else begin
      ch3_gain_sel <= ctrl_q[dsc_pkg::F_GA3];
      ch4_gain_sel <= ctrl_q[dsc_pkg::F_GA4];
      ch2_polarity_flip <= ctrl_q[dsc_pkg::F_INV2];
      lamp_suppress <= ctrl_q[dsc_pkg::F_LAMP];
      single_sequence_mode <= ctrl_q[dsc_pkg::F_SGL];
      intensity_drive <= ro_mode ? ctrl_q[dsc_pkg::F_ROIN +: 8]
                                 : ctrl_q[dsc_pkg::F_INTN +: 8];
    end
  end

  a_gain_follow: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    $rose(load_q) |-> ##2 ch3_gain_sel == ctrl_q[dsc_pkg::F_GA3])
    else $error("channel 3 gain did not follow load");

  // status readback; captured when idle, shifted out per strobe
  logic [dsc_pkg::STAT_BITS-1:0] stat_q;
  logic [1:0] scnt_q;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      stat_q <= '0;
      scnt_q <= '0;
      status_serial_out <= 1'b0;
    end else begin
      if (sstb_rise) begin
        stat_q <= {stat_q[dsc_pkg::STAT_BITS-2:0], 1'b0};
        scnt_q <= scnt_q + 2'h1;
        if (scnt_q == 2'h3) stat_q <= {sga_s, sgb_s, tsa_s, tsb_s};
      end else if (scnt_q == 2'h0) begin
        stat_q <= {sga_s, sgb_s, tsa_s, tsb_s};
      end
      status_serial_out <= stat_q[dsc_pkg::STAT_BITS-1];
    end
  end

  a_status_shift: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (sstb_rise && scnt_q != 2'h3) |=>
    stat_q[dsc_pkg::STAT_BITS-1] == $past(stat_q[dsc_pkg::STAT_BITS-2]))
    else $error("status did not shift on strobe");
endmodule : dsc_top

/* sim/dsc_host_model.sv */
// host side of the control and status links: shifts strings, reads status
// assumes the sequencer samples these async pins with its own clock
`timescale 1ns/100ps
module dsc_host_model (
  output logic ctrl_clk,
  output logic ctrl_data,
  output logic status_shift_strobe,
  input wire logic status_serial_out
);
  initial begin
    ctrl_clk = 1'b0;
    ctrl_data = 1'b0;
    status_shift_strobe = 1'b0;
  end

  // msb first; link clock stands still between frames
  task automatic send(input logic [54:0] w);
    for (int i = 54; i >= 0; i--) begin
      #50 ctrl_data = w[i];
      #50 ctrl_clk = 1'b1;
      #100 ctrl_clk = 1'b0;
    end
    // released line must not keep showing the last bit
    #50 ctrl_data = ~ctrl_data;
  endtask : send

  task automatic read_status(output logic [3:0] s);
    for (int i = 3; i >= 0; i--) begin
      #100 s[i] = status_serial_out;
      status_shift_strobe = 1'b1;
      #100 status_shift_strobe = 1'b0;
    end
  endtask : read_status
endmodule : dsc_host_model

/* sim/dsc_top_tb_top.sv */
// self-checking bench for the display sequencer control block
// assumes dsc_pkg and dsc_top are compiled first
`timescale 1ns/100ps
module dsc_top_tb_top;
  logic ref_clk, rstn, ctrl_clk, ctrl_data, status_shift_strobe;
  logic sweep_gate_a_n, sweep_gate_b_n, trig_state_a, trig_state_b;
  logic readout_request_n, chop_phase, status_serial_out;
  logic vert_select_1_n, vert_select_2_n, vert_select_3_n, vert_select_4_n;
  logic horiz_select_a_n, horiz_select_b_n, trig_holdoff, beam_off;
  logic trig_a_src_bit0, trig_a_src_bit1, trig_a_src_bit2;
  logic trig_b_src_bit0, trig_b_src_bit1, trig_b_src_bit2;
  logic delay_ref_select_n, readout_permit_n, ch3_gain_sel, ch4_gain_sel;
  logic ch2_polarity_flip, lamp_suppress, single_sequence_mode;
  logic [7:0] intensity_drive;
  dsc_pkg::dsc_sel_t sel, m;
  logic [54:0] w, cur;
  logic [3:0] r, got;
  logic [5:0] trg_q;
  logic ho_q;
  int fails = 0, checked = 0, n, lim;

  dsc_top u_dsc_top (.ref_clk, .rstn, .ctrl_clk, .ctrl_data,
    .status_shift_strobe, .sweep_gate_a_n, .sweep_gate_b_n, .trig_state_a,
    .trig_state_b, .readout_request_n, .chop_phase, .status_serial_out,
    .vert_select_1_n, .vert_select_2_n, .vert_select_3_n, .vert_select_4_n,
    .horiz_select_a_n, .horiz_select_b_n, .trig_a_src_bit0,
    .trig_a_src_bit1, .trig_a_src_bit2, .trig_b_src_bit0, .trig_b_src_bit1,
    .trig_b_src_bit2, .trig_holdoff, .delay_ref_select_n, .beam_off,
    .readout_permit_n, .intensity_drive, .ch3_gain_sel, .ch4_gain_sel,
    .ch2_polarity_flip, .lamp_suppress, .single_sequence_mode);
  dsc_host_model u_dsc_host_model (.ctrl_clk, .ctrl_data,
    .status_shift_strobe, .status_serial_out);

  assign sel = {vert_select_4_n, vert_select_3_n, vert_select_2_n,
    vert_select_1_n, horiz_select_b_n, horiz_select_a_n, trig_a_src_bit2,
    trig_a_src_bit1, trig_a_src_bit0, trig_b_src_bit2, trig_b_src_bit1,
    trig_b_src_bit0, delay_ref_select_n};

  function automatic dsc_pkg::dsc_sel_t model(input logic [54:0] v);
    return {v[dsc_pkg::F_VSEL+:4], v[dsc_pkg::F_HSEL+:2],
      v[dsc_pkg::F_TRGA+:3], v[dsc_pkg::F_TRGB+:3], v[dsc_pkg::F_DSEL]};
  endfunction : model

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    if (fails == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #2;
  endtask : cyc

  // bounded wait for holdoff to end; n is the cycle count spent
  task automatic wait_hold;
    n = 0;
    while (trig_holdoff === 1'b1 && n < 3000) begin
      cyc(1);
      n++;
    end
    if (n == 3000) begin
      fails++;
      stop_test();
    end
  endtask : wait_hold

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // sampled mid-cycle so design updates have landed
  always @(negedge ref_clk) begin
    if (rstn && !ho_q && trig_holdoff === 1'b0 && sel[6:1] !== trg_q)
      check(0, 1);
    if (rstn && readout_permit_n === 1'b0) check(trig_holdoff, 1);
    ho_q <= trig_holdoff;
    trg_q <= sel[6:1];
  end

  initial begin
    rstn = 1'b0;
    {sweep_gate_a_n, sweep_gate_b_n, trig_state_a, trig_state_b} = 4'h0;
    readout_request_n = 1'b1;
    chop_phase = 1'b0;
    cur = 55'h0;
    n = $urandom(92205);
    cyc(5);
    check({sel[12:7], trig_holdoff, beam_off, readout_permit_n, sel[6:1]},
      15'h7FC0);
    rstn = 1'b1;
    for (int k = 0; k < 4; k++) begin
      w = 55'({$urandom, $urandom});
      w[dsc_pkg::F_VTRG] = 1'b0;
      w[dsc_pkg::F_CHOP] = 1'(k); // chop blanking on odd passes only
      w[dsc_pkg::F_SGL] = (k >= 2);
      w[dsc_pkg::F_LAMP] = (k == 2);
      chop_phase = 1'($urandom);
      fork
        u_dsc_host_model.send(w);
        begin
          #6000 check(sel, model(cur));
        end
      join
      cur = w;
      cyc(5);
      check(beam_off, 1);
      m = model(w);
      check({sel[12:7], sel[0]}, {m[12:7], m[0]});
      check({single_sequence_mode, lamp_suppress, ch2_polarity_flip,
        ch4_gain_sel, ch3_gain_sel}, w[20:16]);
      check(intensity_drive, w[dsc_pkg::F_INTN+:8]);
      lim = w[dsc_pkg::F_HOLD+:8] * dsc_pkg::HOLD_SCALE +
        dsc_pkg::RO_GUARD + 1;
      wait_hold();
      check(n <= lim && n + 12 >= lim, 1);
      check(sel[6:1], m[6:1]);
      // a chop phase change blanks the beam only in chopped mode
      chop_phase = ~chop_phase;
      cyc(3);
      check(beam_off, w[dsc_pkg::F_CHOP]);
    end
    // track mode: trigger A follows the sweep-end channel sequence
    w[dsc_pkg::F_VTRG] = 1'b1;
    w[dsc_pkg::F_ALVL] = 1'b0;
    w[dsc_pkg::F_CHOP] = 1'b0;
    u_dsc_host_model.send(w);
    cur = w;
    cyc(5);
    wait_hold();
    check(sel.trg_a, 3'h0);
    sweep_gate_a_n = 1'b1;
    cyc(6);
    check({sel[12:7], intensity_drive}, {dsc_pkg::VSEL_READOUT,
      dsc_pkg::HSEL_READOUT, w[dsc_pkg::F_ROIN+:8]});
    sweep_gate_a_n = 1'b0;
    cyc(1);
    wait_hold();
    check(sel.trg_a, 3'h1);
    readout_request_n = 1'b0;
    cyc(5);
    check({sel[12:7], intensity_drive}, {dsc_pkg::VSEL_READOUT,
      dsc_pkg::HSEL_READOUT, cur[dsc_pkg::F_ROIN+:8]});
    readout_request_n = 1'b1;
    cyc(5);
    m = model(cur);
    check(sel[12:7], m[12:7]);
    for (int k = 0; k < 4; k++) begin
      r = 4'($urandom);
      {sweep_gate_a_n, sweep_gate_b_n, trig_state_a, trig_state_b} = r;
      cyc(5);
      u_dsc_host_model.read_status(got);
      check(got, r);
    end
    stop_test();
  end
endmodule : dsc_top_tb_top
